// >>> rtl/dbs_pkg.sv
`default_nettype none

package dbs_pkg;

   localparam int DATA_W = 36;
   localparam int ADDR_W = 17;
   localparam int LANE_W = 9;
   localparam int LANES = DATA_W / LANE_W;
   localparam int BEATS = 4;
   localparam int LAT_DLL = 2;
   localparam int LAT_BYPASS = 1;
   localparam int BUF_DEPTH = 2;
   localparam logic RST_LOW = 1'h0;
   localparam logic [1:0] RST_SYNC_SET = 2'h3;

   typedef logic [BEATS-1:0][DATA_W-1:0] dbs_entry_t;
   typedef logic [BEATS-1:0][LANES-1:0] dbs_mask_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      dbs_entry_t data;
   } dbs_load_t;

   typedef enum logic [1:0] {RD_IDLE, RD_FIRST, RD_SECOND} dbs_rd_t;

endpackage

`default_nettype wire

// >>> rtl/dbs_buf2.sv
`default_nettype none

module dbs_buf2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

   logic [WIDTH-1:0] slot [DEPTH];
   logic [PW-1:0] wp;
   logic [PW-1:0] rp;
   logic [PW:0] cnt;
   logic [PW:0] next_cnt;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign next_cnt = cnt + (PW + 1)'(push) - (PW + 1)'(pop);
   assign out_data_o = slot[rp];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         slot[wp] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         in_ready_o <= 1'h0;
         out_valid_o <= 1'h0;
      end
      else
      begin
         if (push)
         begin
            wp <= (wp == LAST) ? '0 : wp + 1'h1;
         end
         if (pop)
         begin
            rp <= (rp == LAST) ? '0 : rp + 1'h1;
         end
         cnt <= next_cnt;
         // Flags are registered so a full buffer refuses cleanly.
         in_ready_o <= (next_cnt != FULL);
         out_valid_o <= (next_cnt != '0);
      end
   end

endmodule // dbs_buf2

`default_nettype wire

// >>> rtl/dbs_sram_port.sv
`default_nettype none

module dbs_sram_port #(
   parameter int DATA_W = dbs_pkg::DATA_W,
   parameter int ADDR_W = dbs_pkg::ADDR_W
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire dbs_pkg::dbs_load_t load_i,
   input wire logic load_valid_i,
   output logic load_ready_o,
   output logic load_busy_o,
   input wire logic k_clk_i,
   input wire logic k_clk_n_i,
   input wire logic load_select_n_i,
   input wire logic read_write_i,
   input wire logic [ADDR_W-1:0] sync_addr_bus_i,
   input wire logic [dbs_pkg::LANES-1:0] byte_lane_write_n_i,
   input wire logic [DATA_W-1:0] dq_i,
   input wire logic dll_bypass_n_i,
   output logic [DATA_W-1:0] q_rise_o,
   output logic [DATA_W-1:0] q_fall_o,
   output logic q_oe_rise_o,
   output logic q_oe_fall_o,
   output logic read_valid_flag_rise_o,
   output logic read_valid_flag_fall_o,
   output logic echo_clock_true_o,
   output logic echo_clock_comp_o
);

   import dbs_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [1:0] k_rst_pipe;
   logic k_rst;
   logic dll_q1;
   logic dll_on;
   logic busy;
   logic cmd_sel;
   logic rd_take;
   logic wr_take;
   logic wr_s1;
   logic wr_s2;
   logic wr_s3;
   logic rd_p1;
   logic rd_p2;
   logic launch;
   logic [ADDR_W-1:0] cmd_addr;
   logic [ADDR_W-1:0] wa2;
   logic [ADDR_W-1:0] wa3;
   logic [ADDR_W-1:0] rd_addr;
   logic [ADDR_W-1:0] ra_sel;
   logic [DATA_W-1:0] wd_k0;
   logic [DATA_W-1:0] wd_k1;
   logic [DATA_W-1:0] wd_n0;
   logic [DATA_W-1:0] wd_n1;
   logic [LANES-1:0] bm_k0;
   logic [LANES-1:0] bm_k1;
   logic [LANES-1:0] bm_n0;
   logic [LANES-1:0] bm_n1;
   dbs_entry_t wr_new;
   dbs_mask_t wr_mask;
   dbs_entry_t wr_merged;
   dbs_entry_t rd_entry;
   dbs_entry_t rd_buf;
   dbs_rd_t rd_ph;
   dbs_entry_t mem [2**ADDR_W];
   logic buf_valid;
   logic buf_ready;
   dbs_load_t buf_data;
   dbs_load_t ld_hold;
   logic ld_req;
   logic ack_q1;
   logic ack_s;
   logic req_q1;
   logic req_s;
   logic ld_ack;
   logic ld_go;

   function automatic dbs_entry_t merge_lanes(input dbs_entry_t old_e,
                                              input dbs_entry_t new_e,
                                              input dbs_mask_t wn);
      dbs_entry_t res;
      res = old_e;
      for (int b = 0; b < BEATS; b++)
      begin
         for (int l = 0; l < LANES; l++)
         begin
            if (!wn[b][l])
            begin
               res[b][l*LANE_W +: LANE_W] = new_e[b][l*LANE_W +: LANE_W];
            end
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Link-side reset and bypass pin synchronisers.

   // The link has no reset pin, so the system reset is released in step
   // with the input clock.
   always_ff @(posedge k_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         k_rst_pipe <= RST_SYNC_SET;
      end
      else
      begin
         k_rst_pipe <= {k_rst_pipe[0], RST_LOW};
      end
   end
   assign k_rst = k_rst_pipe[1];

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         dll_q1 <= 1'h0;
         dll_on <= 1'h0;
      end
      else
      begin
         dll_q1 <= dll_bypass_n_i;
         dll_on <= dll_q1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decode on the true clock.

   assign busy = wr_s1 | rd_p1;
   assign cmd_sel = !load_select_n_i && !busy;
   assign rd_take = cmd_sel && read_write_i;
   assign wr_take = cmd_sel && !read_write_i;
   assign launch = (rd_p1 && !dll_on) || rd_p2;
   assign ra_sel = rd_p2 ? rd_addr : cmd_addr;

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         wr_s1 <= 1'h0;
         wr_s2 <= 1'h0;
         wr_s3 <= 1'h0;
         rd_p1 <= 1'h0;
         rd_p2 <= 1'h0;
      end
      else
      begin
         wr_s1 <= wr_take;
         wr_s2 <= wr_s1;
         wr_s3 <= wr_s2;
         rd_p1 <= rd_take;
         rd_p2 <= rd_p1 && dll_on;
      end
   end

   // The command address is only loaded while selected; a deselected edge keeps the
   // previous burst address intact.
   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         cmd_addr <= '0;
         wa2 <= '0;
         wa3 <= '0;
         rd_addr <= '0;
      end
      else
      begin
         if (cmd_sel)
         begin
            cmd_addr <= sync_addr_bus_i;
         end
         if (wr_s1)
         begin
            wa2 <= cmd_addr;
         end
         if (wr_s2)
         begin
            wa3 <= wa2;
         end
         if (rd_p1)
         begin
            rd_addr <= cmd_addr;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write data capture on both input clocks.

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         wd_k0 <= '0;
         wd_k1 <= '0;
         bm_k0 <= '1;
         bm_k1 <= '1;
      end
      else
      begin
         if (wr_s1)
         begin
            wd_k0 <= dq_i;
            bm_k0 <= byte_lane_write_n_i;
         end
         if (wr_s2)
         begin
            wd_k1 <= dq_i;
            bm_k1 <= byte_lane_write_n_i;
         end
      end
   end

   always_ff @(posedge k_clk_n_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         wd_n0 <= '0;
         wd_n1 <= '0;
         bm_n0 <= '1;
         bm_n1 <= '1;
      end
      else
      begin
         if (wr_s2)
         begin
            wd_n0 <= dq_i;
            bm_n0 <= byte_lane_write_n_i;
         end
         if (wr_s3)
         begin
            wd_n1 <= dq_i;
            bm_n1 <= byte_lane_write_n_i;
         end
      end
   end

   assign wr_new = {wd_n1, wd_k1, wd_n0, wd_k0};
   assign wr_mask = {bm_n1, bm_k1, bm_n0, bm_k0};
   assign wr_merged = merge_lanes(mem[wa3], wr_new, wr_mask);

   ////////////////////////////////////////////////////////////////////////
   // Array, write commit and coherent read fetch.

   // A port write always wins the array; a preload simply waits an edge.
   assign ld_go = (req_s != ld_ack) && !wr_s3;

   always_ff @(posedge k_clk_i)
   begin
      if (wr_s3)
      begin
         mem[wa3] <= wr_merged;
      end
      else if (ld_go)
      begin
         mem[ld_hold.addr] <= ld_hold.data;
      end
   end

   always_comb
   begin
      if (wr_s3 && (wa3 == ra_sel))
      begin
         rd_entry = wr_merged;
      end
      else if (ld_go && (ld_hold.addr == ra_sel))
      begin
         rd_entry = ld_hold.data;
      end
      else
      begin
         rd_entry = mem[ra_sel];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read launch on both clocks, valid flag and echo clocks.

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         rd_ph <= RD_IDLE;
         rd_buf <= '0;
         q_rise_o <= '0;
         q_oe_rise_o <= 1'h0;
         read_valid_flag_rise_o <= 1'h0;
      end
      else
      begin
         if (launch)
         begin
            rd_ph <= RD_FIRST;
            rd_buf <= rd_entry;
            q_rise_o <= rd_entry[0];
         end
         else
         begin
            unique case (rd_ph)
               RD_FIRST:
               begin
                  rd_ph <= RD_SECOND;
                  q_rise_o <= rd_buf[2];
               end
               RD_SECOND: rd_ph <= RD_IDLE;
               RD_IDLE: rd_ph <= RD_IDLE;
               default: rd_ph <= RD_IDLE;
            endcase
         end
         q_oe_rise_o <= launch || (rd_ph == RD_FIRST);
         read_valid_flag_rise_o <= launch || (rd_ph == RD_FIRST);
      end
   end

   always_ff @(posedge k_clk_n_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         q_fall_o <= '0;
         q_oe_fall_o <= 1'h0;
         read_valid_flag_fall_o <= 1'h0;
      end
      else
      begin
         q_fall_o <= (rd_ph == RD_SECOND) ? rd_buf[3] : rd_buf[1];
         q_oe_fall_o <= (rd_ph != RD_IDLE);
         read_valid_flag_fall_o <= (rd_ph != RD_IDLE);
      end
   end

   // Both echo halves toggle on every edge regardless of traffic, so the
   // controller can keep its capture clocks running through idle time.
   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         echo_clock_true_o <= 1'h0;
      end
      else
      begin
         echo_clock_true_o <= ~echo_clock_true_o;
      end
   end

   always_ff @(posedge k_clk_n_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         echo_clock_comp_o <= 1'h0;
      end
      else
      begin
         echo_clock_comp_o <= ~echo_clock_comp_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Preload path from the system clock with a toggle handshake.

   dbs_buf2 #(
      .WIDTH($bits(dbs_load_t)),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk_i(clk_i),
      .rst_i(sys_rst_i),
      .in_valid_i(load_valid_i),
      .in_data_i(load_i),
      .in_ready_o(load_ready_o),
      .out_valid_o(buf_valid),
      .out_data_o(buf_data),
      .out_ready_i(buf_ready)
   );

   assign buf_ready = (ld_req == ack_s);

   // The held word stays still until the link side echoes the toggle, so
   // it can be read across the domains without a data synchroniser.
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ld_hold <= '0;
         ld_req <= 1'h0;
         ack_q1 <= 1'h0;
         ack_s <= 1'h0;
         load_busy_o <= 1'h0;
      end
      else
      begin
         ack_q1 <= ld_ack;
         ack_s <= ack_q1;
         if (buf_valid && buf_ready)
         begin
            ld_hold <= buf_data;
            ld_req <= ~ld_req;
         end
         load_busy_o <= buf_valid || (ld_req != ack_s);
      end
   end

   always_ff @(posedge k_clk_i or posedge k_rst)
   begin
      if (k_rst)
      begin
         req_q1 <= 1'h0;
         req_s <= 1'h0;
         ld_ack <= 1'h0;
      end
      else
      begin
         req_q1 <= ld_req;
         req_s <= req_q1;
         if (ld_go)
         begin
            ld_ack <= req_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_burst_four;
      @(posedge k_clk_i) disable iff (k_rst)
      launch |=> (read_valid_flag_rise_o && q_oe_rise_o)
         ##1 read_valid_flag_rise_o;
   endproperty
   a_burst_four: assert property (p_burst_four)
      else $error("read burst shorter than four beats");

   property p_burst_end;
      @(posedge k_clk_i) disable iff (k_rst)
      launch ##1 !launch ##1 !launch |=> !read_valid_flag_rise_o;
   endproperty
   a_burst_end: assert property (p_burst_end)
      else $error("read burst longer than four beats");

   property p_lat_dll;
      @(posedge k_clk_i) disable iff (k_rst)
      (rd_take && dll_on) |=> !launch ##1 launch;
   endproperty
   a_lat_dll: assert property (p_lat_dll)
      else $error("read latency is not two cycles");

   property p_lat_bypass;
      @(posedge k_clk_i) disable iff (k_rst)
      (rd_take && !dll_on) |-> ##1 launch;
   endproperty
   a_lat_bypass: assert property (p_lat_bypass)
      else $error("bypass read latency is not one cycle");

   property p_echo_free;
      @(posedge k_clk_i) disable iff (k_rst)
      !k_rst |=> (echo_clock_true_o != $past(echo_clock_true_o));
   endproperty
   a_echo_free: assert property (p_echo_free)
      else $error("echo clock stopped");

   property p_deselect;
      @(posedge k_clk_i) disable iff (k_rst)
      load_select_n_i |=> !rd_p1 && !wr_s1 && $stable(cmd_addr);
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("deselected edge changed command state");

   property p_commit;
      @(posedge k_clk_i) disable iff (k_rst)
      wr_take |-> ##3 (wr_s3 && (wa3 == $past(sync_addr_bus_i, 3)));
   endproperty
   a_commit: assert property (p_commit)
      else $error("write not committed two cycles after its data");

   property p_forward;
      @(posedge k_clk_i) disable iff (k_rst)
      (launch && wr_s3 && (wa3 == ra_sel)) |=> (rd_buf == $past(wr_merged));
   endproperty
   a_forward: assert property (p_forward)
      else $error("read missed data of the write in flight");

endmodule // dbs_sram_port

`default_nettype wire

// >>> bench/dbs_ctrl_model.sv
`default_nettype none

module dbs_ctrl_model (
   output logic k_o,
   output logic kn_o,
   output logic sel_n_o,
   output logic rw_o,
   output logic [dbs_pkg::ADDR_W-1:0] addr_o,
   output logic [dbs_pkg::LANES-1:0] bw_n_o,
   output logic [dbs_pkg::DATA_W-1:0] dq_o,
   input wire logic [dbs_pkg::DATA_W-1:0] qr_i,
   input wire logic [dbs_pkg::DATA_W-1:0] qf_i,
   input wire logic oer_i,
   input wire logic oef_i,
   input wire logic vr_i,
   input wire logic vf_i,
   output logic clash_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import dbs_pkg::*;
   logic ph;
   logic drv;
   logic dev_oe;
   logic [DATA_W-1:0] wd;
   logic [DATA_W-1:0] idle;

   initial
   begin
      {sel_n_o, rw_o, drv, clash_o} = 4'h8;
      addr_o = '0;
      bw_n_o = '1;
      wd = '0;
      idle = {9{4'h5}};
      ph = 1'h1;
      k_o = 1'h0;
      forever #16 k_o = ~k_o;
   end
   assign kn_o = ~k_o;
   assign dev_oe = ph ? oer_i : oef_i;
   // A released bus changes every edge, so a stale value never passes.
   assign dq_o = drv ? wd : (dev_oe ? (ph ? qr_i : qf_i) : idle);

   always @(posedge k_o or posedge kn_o)
   begin
      ph <= k_o;
      idle <= ~idle;
      if (drv && dev_oe)
         clash_o <= 1'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   // A stray select right after the command exercises the refused case.
   task automatic wr(input logic [ADDR_W-1:0] a, input dbs_entry_t d,
                     input dbs_mask_t bn, input logic stray);
      @(posedge k_o);
      sel_n_o <= 1'h0;
      rw_o <= 1'h0;
      addr_o <= a;
      @(posedge k_o);
      sel_n_o <= ~stray;
      rw_o <= 1'h1;
      addr_o <= ~a;
      drv <= 1'h1;
      wd <= d[0];
      bw_n_o <= bn[0];
      @(posedge k_o);
      if (stray)
         sel_n_o <= 1'h1;
      wd <= d[1];
      bw_n_o <= bn[1];
      @(posedge kn_o);
      wd <= d[2];
      bw_n_o <= bn[2];
      @(posedge k_o);
      wd <= d[3];
      bw_n_o <= bn[3];
      @(posedge kn_o);
      drv <= 1'h0;
      bw_n_o <= '1;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input int lat,
                     output dbs_entry_t d, output logic ok);
      @(posedge k_o);
      sel_n_o <= 1'h0;
      rw_o <= 1'h1;
      addr_o <= a;
      @(posedge k_o);
      sel_n_o <= 1'h1;
      addr_o <= ~a;
      ok = 1'h1;
      repeat (lat - 1) @(posedge k_o);
      #1;
      ok &= !vr_i;
      for (int i = 0; i < 2; i++)
      begin
         @(posedge k_o);
         #1;
         d[2*i] = qr_i;
         ok &= oer_i & vr_i;
         @(posedge kn_o);
         #1;
         d[2*i+1] = qf_i;
         ok &= oef_i & vf_i;
      end
      @(posedge k_o);
      #1;
      ok &= !oer_i & !vr_i;
   endtask
endmodule // dbs_ctrl_model

`default_nettype wire

// >>> bench/dbs_sram_port_tb.sv
`default_nettype none

module dbs_sram_port_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dbs_pkg::*;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] fill;
      dbs_mask_t bw_n;
   } dbs_row_t;

   localparam dbs_row_t ROWS [5] = '{
      '{17'h00005, 8'h11, 16'h0000},
      '{17'h00005, 8'h22, 16'h5a3c},
      '{17'h1ffff, 8'h33, 16'h0000},
      '{17'h00000, 8'h44, 16'h0000},
      '{17'h1ffff, 8'h55, 16'hffff}
   };

   logic clk_i, sys_rst_i, load_valid_i, load_ready_o, load_busy_o;
   dbs_load_t load_i;
   logic k, kn, sel_n, rw, oe_r, oe_f, v_r, v_f, echo_t, echo_c;
   logic clash, bypass_n, ok, e_prev, rdy;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0] bw_n;
   logic [DATA_W-1:0] dq, q_r, q_f;
   int error_cnt, checks_done, n, stalls;
   dbs_entry_t got;
   dbs_entry_t exp_mem [int];
   dbs_row_t r;

   dbs_sram_port u_dbs_sram_port (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .load_i(load_i),
      .load_valid_i(load_valid_i),
      .load_ready_o(load_ready_o),
      .load_busy_o(load_busy_o),
      .k_clk_i(k),
      .k_clk_n_i(kn),
      .load_select_n_i(sel_n),
      .read_write_i(rw),
      .sync_addr_bus_i(addr),
      .byte_lane_write_n_i(bw_n),
      .dq_i(dq),
      .dll_bypass_n_i(bypass_n),
      .q_rise_o(q_r),
      .q_fall_o(q_f),
      .q_oe_rise_o(oe_r),
      .q_oe_fall_o(oe_f),
      .read_valid_flag_rise_o(v_r),
      .read_valid_flag_fall_o(v_f),
      .echo_clock_true_o(echo_t),
      .echo_clock_comp_o(echo_c)
   );

   dbs_ctrl_model u_dbs_ctrl_model (
      .k_o(k),
      .kn_o(kn),
      .sel_n_o(sel_n),
      .rw_o(rw),
      .addr_o(addr),
      .bw_n_o(bw_n),
      .dq_o(dq),
      .qr_i(q_r),
      .qf_i(q_f),
      .oer_i(oe_r),
      .oef_i(oe_f),
      .vr_i(v_r),
      .vf_i(v_f),
      .clash_o(clash)
   );

   ////////////////////////////////////////////////////////////////////////
   function automatic dbs_entry_t pat(input logic [7:0] s);
      for (int b = 0; b < BEATS; b++)
         pat[b] = {LANES{s ^ 8'(b), 1'h1}};
   endfunction

   function automatic dbs_entry_t merge(input dbs_entry_t o, input dbs_entry_t w,
                                         input dbs_mask_t bn);
      merge = o;
      for (int b = 0; b < BEATS; b++)
         for (int l = 0; l < LANES; l++)
            if (!bn[b][l])
               merge[b][l*LANE_W +: LANE_W] = w[b][l*LANE_W +: LANE_W];
   endfunction

   task automatic chk(input dbs_entry_t g, input dbs_entry_t e);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %0t: got %h exp %h", $time, g, e);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      clk_i = 1'h0;
      forever #25 clk_i = ~clk_i;
   end

   // The whole sequence needs well under a tenth of this span.
   initial
   begin
      #2000000;
      error_cnt++;
      $display("[FAIL] %0t: watchdog expired", $time);
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_rst_i = 1'h1;
      load_i = '0;
      load_valid_i = 1'h0;
      bypass_n = 1'h1;
      error_cnt = 0;
      checks_done = 0;
      stalls = 0;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      @(posedge clk_i);
      @(negedge clk_i);
      chk(dbs_entry_t'({load_ready_o, oe_r, v_r, v_f}), 144'h8);
      repeat (10) @(posedge k);
      #1;
      e_prev = echo_t ^ echo_c;
      repeat (8)
      begin
         @(posedge k or posedge kn);
         #1;
         chk(dbs_entry_t'(e_prev ^ echo_t ^ echo_c), 144'h1);
         e_prev = echo_t ^ echo_c;
      end
      foreach (ROWS[i])
      begin
         r = ROWS[i];
         u_dbs_ctrl_model.wr(r.addr, pat(r.fill), r.bw_n, 1'h0);
         got = exp_mem.exists(r.addr) ? exp_mem[r.addr] : '0;
         exp_mem[r.addr] = merge(got, pat(r.fill), r.bw_n);
         u_dbs_ctrl_model.rd(r.addr, 2, got, ok);
         chk(got, exp_mem[r.addr]);
         chk(dbs_entry_t'(ok), 144'h1);
      end
      // The read is taken before the write commits; launch sees the new word.
      fork
         u_dbs_ctrl_model.wr(17'h00009, pat(8'h77), '0, 1'h0);
         begin
            repeat (2) @(posedge k);
            u_dbs_ctrl_model.rd(17'h00009, 2, got, ok);
         end
      join
      chk(got, pat(8'h77));
      u_dbs_ctrl_model.wr(17'h0000a, pat(8'h88), '0, 1'h1);
      n = 0;
      repeat (16)
      begin
         @(posedge k or posedge kn);
         #1;
         n += v_r | v_f | oe_r | oe_f;
      end
      chk(dbs_entry_t'(n), 144'h0);
      u_dbs_ctrl_model.rd(17'h0000a, 2, got, ok);
      chk(got, pat(8'h88));
      @(posedge clk_i);
      bypass_n <= 1'h0;
      repeat (8) @(posedge k);
      // Bypass latency launches on the commit edge, so the read forwards.
      fork
         u_dbs_ctrl_model.wr(17'h0000b, pat(8'h99), '0, 1'h0);
         begin
            repeat (2) @(posedge k);
            u_dbs_ctrl_model.rd(17'h0000b, 1, got, ok);
         end
      join
      chk(got, pat(8'h99));
      chk(dbs_entry_t'(ok), 144'h1);
      @(posedge clk_i);
      bypass_n <= 1'h1;
      repeat (8) @(posedge k);
      @(posedge clk_i);
      for (int i = 0; i < 4; i++)
      begin
         load_i.addr <= 17'h00100 + 17'(i);
         load_i.data <= pat(8'hc0 + 8'(i));
         load_valid_i <= 1'h1;
         n = 0;
         do
         begin
            @(negedge clk_i);
            rdy = load_ready_o;
            @(posedge clk_i);
            stalls += !rdy;
            n++;
         end while (!rdy && n < 100);
      end
      load_valid_i <= 1'h0;
      n = 0;
      while (load_busy_o !== 1'h0 && n < 200)
      begin
         @(negedge clk_i);
         n++;
      end
      chk(dbs_entry_t'(stalls > 0 && n < 200), 144'h1);
      for (int i = 0; i < 4; i++)
      begin
         u_dbs_ctrl_model.rd(17'h00100 + 17'(i), 2, got, ok);
         chk(got, pat(8'hc0 + 8'(i)));
      end
      chk(dbs_entry_t'(clash), 144'h0);
      close_out();
   end
endmodule // dbs_sram_port_tb

`default_nettype wire
